// ==== rtl/gpib_exec_consts.svh ====
`ifndef GPIB_EXEC_CONSTS_SVH
`define GPIB_EXEC_CONSTS_SVH

// status byte bit positions (bit 1 of the byte is index 0)
`define SB_BUSY_BIT      4
`define SB_ABN_BIT       5
`define SB_SRQ_BIT       6
`define SB_ZERO_BIT      7

// four-bit condition codes
`define CODE_ORDINARY    4'h0
`define CODE_PWRON       4'h1
`define CODE_EOS         4'h2
`define CODE_CMD_ERR     4'h1
`define CODE_EXEC_ERR    4'h2
`define CODE_INT_ERR     4'h3
`define CODE_EXEC_WARN   4'h5
`define CODE_INT_WARN    4'h6

// enable reset values
`define RST_SWEEP_REQ_EN 1'b0
`define RST_SERVICE_EN   1'b1
`define RST_WARN_EN      1'b1

// warning numbers
`define WARN_50          8'h32
`define WARN_52          8'h34
`define WARN_53          8'h35
`define WARN_54          8'h36
`define WARN_110         8'h6E
`define WARN_111         8'h6F
`define WARN_130         8'h82

// repeat loop
`define REPEAT_COUNT_W   24
`define LOCAL_REP_CAP    24'h000100

// status stack and event slots, lowest index served first
`define STACK_DEPTH      8
`define EV_COUNT         7
`define EV_PWRON         3'h0
`define EV_INT_ERR       3'h1
`define EV_CMD_ERR       3'h2
`define EV_EXEC_ERR      3'h3
`define EV_EXEC_WARN     3'h4
`define EV_INT_WARN      3'h5
`define EV_EOS           3'h6

// strap capture point after reset release
`define BOOT_CAPTURE     2'h2
`define BOOT_LAST        2'h3

`endif

// ==== rtl/gpib_exec_pkg.sv ====
`include "gpib_exec_consts.svh"
package gpib_exec_pkg;

  typedef enum logic [1:0] {
    UNIT_ORDINARY = 2'h0,
    UNIT_WAIT     = 2'h1,
    UNIT_REPEAT   = 2'h3
  } unit_kind_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1
  } exec_state_e;

  typedef struct packed {
    unit_kind_e                  kind;
    logic                        frontPanel;
    logic [7:0]                  pos;
    logic [`REPEAT_COUNT_W-1:0]  count;
  } msg_unit_s;

  typedef struct packed {
    logic       srq;
    logic       abnormal;
    logic [3:0] code;
  } status_entry_s;

  typedef struct packed {
    logic sweepDoneReq;
    logic serviceReq;
    logic warningReport;
  } enable_cfg_s;

endpackage

// ==== rtl/status_stack.sv ====
`timescale 1ns/100ps
module status_stack #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  // write side
  input  wire logic               push,
  input  wire logic [WIDTH-1:0]   pushData,
  // read side
  input  wire logic               pop,
  output logic      [WIDTH-1:0]   headData,
  output logic [$clog2(DEPTH):0]  count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW-1:0]    next_wrPtr;
  logic [AW-1:0]    next_rdPtr;
  logic [CW-1:0]    next_count;
  logic [WIDTH-1:0] next_headData;
  logic             doPush;
  logic             doPop;

  always_comb begin
    doPush        = push && (count != CW'(DEPTH));
    doPop         = pop && (count != '0);
    next_wrPtr    = doPush ? AW'(wrPtr + 1'b1) : wrPtr;
    next_rdPtr    = doPop ? AW'(rdPtr + 1'b1) : rdPtr;
    next_count    = CW'(count + CW'(doPush) - CW'(doPop));
    next_headData = (doPush && next_rdPtr == wrPtr) ? pushData : mem[next_rdPtr];
  end

  always_ff @(posedge core_clk) begin
    if (doPush) begin
      mem[wrPtr] <= pushData;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr    <= '0;
      rdPtr    <= '0;
      count    <= '0;
      headData <= '0;
    end else begin
      wrPtr    <= next_wrPtr;
      rdPtr    <= next_rdPtr;
      count    <= next_count;
      headData <= next_headData;
    end
  end

endmodule

// ==== rtl/gpib_status_and_message_exec.sv ====
// Operation
// R1 - wait holds later units, busy, no input
// R2 - end of sweep ends the wait
// R3 - single sweep unarmed: wait is skipped
// R4 - device clear ends wait, flushes buffers
// R5 - repeat replays preceding units count times
// R6 - inner repeat acts on first pass only
// R7 - only device clear aborts repeat loop
// R8 - local return caps repetitions at 256
// R9 - sweep done raises request when enabled
// R10 - talk or listen only forces enables off
// R11 - service enable masks abnormal requests
// R12 - warning enable gates all warning reports
// R13 - serial poll returns the status byte
// R14 - strap selects unmaskable power-on status
// R15 - status byte field layout, bit 8 zero
// R16 - normal codes: ordinary, sweep, power-on
// R17 - command error gives abnormal code 0001
// R18 - execution 0010, internal error 0011
// R19 - warnings give codes 0101 and 0110
// R20 - busy while processing buffer or waiting
// R21 - sweep status after trace memory updated
// R22 - poll clears reported entry, next follows
// R23 - busy listener holds not ready for data
// R24 - eight-deep stack keeps oldest, drops normal
`include "gpib_exec_consts.svh"
`timescale 1ns/100ps
module gpib_status_and_message_exec
  import gpib_exec_pkg::*;
#(
  parameter int DEPTH = `STACK_DEPTH
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // message units from the input buffer
  input  wire logic       unitValid,
  input  wire msg_unit_s  unitIn,
  output logic            unitTake,
  output logic            rewind,
  output logic            flushBuffers,
  // instrument engine
  output logic            execStrobe,
  output msg_unit_s       execUnit,
  input  wire logic       engineBusy,
  // sweep
  input  wire logic       singleSweepMode,
  input  wire logic       singleSweepArm,
  input  wire logic       sweepFinished,
  input  wire logic       traceUpdated,
  // bus interface functions
  input  wire logic       devClear,
  input  wire logic       selDevClear,
  input  wire logic       listenAddressed,
  input  wire logic       talkOnly,
  input  wire logic       listenOnly,
  input  wire logic       spollDone,
  output logic [7:0]      statusByte,
  output logic            srq,
  output logic            nrfd,
  output logic            busy,
  // front panel and strap
  input  wire logic       frontPanelLocalReturn,
  input  wire logic       powerOnStrap,
  // enables
  input  wire logic       enableWrite,
  input  wire enable_cfg_s enableIn,
  output enable_cfg_s     enableOut,
  // error and warning events
  input  wire logic       cmdError,
  input  wire logic       execError,
  input  wire logic       internalError,
  input  wire logic       warnValid,
  input  wire logic [7:0] warnCode,
  input  wire logic       internalWarn
);
  localparam int CW = $clog2(DEPTH) + 1;
  localparam int CNTW = `REPEAT_COUNT_W;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic isWarnCode(input logic [7:0] c);
    case (c)
      `WARN_50, `WARN_52, `WARN_53, `WARN_54, `WARN_110, `WARN_111, `WARN_130: isWarnCode = 1'b1;
      default: isWarnCode = 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] firstPending(input logic [`EV_COUNT-1:0] p);
    firstPending = 3'h0;
    for (int i = `EV_COUNT - 1; i >= 0; i--) begin
      if (p[i]) begin
        firstPending = 3'(i);
      end
    end
  endfunction

  function automatic status_entry_s entryFor(input logic [2:0] idx, input logic service_request_enable, input logic sweep_done_request_enable);
    entryFor = '{srq: service_request_enable, abnormal: 1'b1, code: `CODE_CMD_ERR};
    case (idx)
      `EV_PWRON:     entryFor = '{srq: 1'b1, abnormal: 1'b0, code: `CODE_PWRON};
      `EV_EOS:       entryFor = '{srq: service_request_enable & sweep_done_request_enable, abnormal: 1'b0, code: `CODE_EOS};
      `EV_CMD_ERR:   entryFor.code = `CODE_CMD_ERR;
      `EV_EXEC_ERR:  entryFor.code = `CODE_EXEC_ERR;
      `EV_INT_ERR:   entryFor.code = `CODE_INT_ERR;
      `EV_EXEC_WARN: entryFor.code = `CODE_EXEC_WARN;
      `EV_INT_WARN:  entryFor.code = `CODE_INT_WARN;
      default: ;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  exec_state_e          state;
  exec_state_e          next_state;
  logic                 loopActive;
  logic                 next_loopActive;
  logic [7:0]           loopPos;
  logic [7:0]           next_loopPos;
  logic [CNTW-1:0]      loopCount;
  logic [CNTW-1:0]      next_loopCount;
  logic [CNTW-1:0]      reps;
  logic [CNTW-1:0]      next_reps;
  logic [CNTW-1:0]      repsPlus;
  logic                 localMode;
  logic                 next_localMode;
  logic                 next_rewind;
  logic                 next_flush;
  logic                 next_execStrobe;
  msg_unit_s            next_execUnit;
  logic                 fpReject;
  logic                 clearAll;
  logic                 sweepPend;
  logic                 next_sweepPend;
  logic                 eosEvent;
  enable_cfg_s          cfg;
  enable_cfg_s          next_cfg;
  logic                 sweepEff;
  logic                 rqsEff;
  logic                 strapMeta;
  logic                 strapSync;
  logic [1:0]           bootCnt;
  logic [1:0]           next_bootCnt;
  logic                 powerOnEvt;
  logic [`EV_COUNT-1:0] raw;
  logic [`EV_COUNT-1:0] pend;
  logic [`EV_COUNT-1:0] next_pend;
  logic [2:0]           pushIdx;
  logic                 stackPush;
  status_entry_s        pushData;
  status_entry_s        head;
  logic [CW-1:0]        count;
  logic [7:0]           next_statusByte;

  ////////////////////////////////////////////////////////////////////////////
  // message execution

  assign clearAll = devClear || (selDevClear && listenAddressed);
  assign repsPlus = CNTW'(reps + 1'b1);
  assign unitTake = unitValid && state == ST_IDLE && !engineBusy && !execStrobe && !rewind && !clearAll
                    && !flushBuffers; // R1 R4
  assign busy = unitValid || state != ST_IDLE || engineBusy || execStrobe || loopActive || rewind; // R20
  assign nrfd = busy && listenAddressed; // R23

  always_comb begin
    next_state      = state;
    next_loopActive = loopActive;
    next_loopPos    = loopPos;
    next_loopCount  = loopCount;
    next_reps       = reps;
    next_localMode  = localMode;
    next_rewind     = 1'b0;
    next_flush      = 1'b0;
    next_execStrobe = 1'b0;
    next_execUnit   = execUnit;
    fpReject        = 1'b0;
    if (!loopActive && !unitValid && state == ST_IDLE) begin
      next_localMode = 1'b0;
    end
    if (frontPanelLocalReturn) begin
      next_localMode = 1'b1; // R7
    end
    if (state == ST_WAIT && eosEvent) begin
      next_state = ST_IDLE; // R2
    end
    if (unitTake) begin
      case (unitIn.kind)
        UNIT_WAIT: begin
          if (!(singleSweepMode && !singleSweepArm)) begin
            next_state = ST_WAIT; // R1 R3
          end
        end
        UNIT_REPEAT: begin
          if (loopActive && unitIn.pos < loopPos) begin
            next_loopActive = loopActive; // R6
          end else if (loopActive && unitIn.pos == loopPos) begin
            if (repsPlus >= loopCount || (localMode && repsPlus >= `LOCAL_REP_CAP)) begin
              next_loopActive = 1'b0; // R5 R8
              next_reps       = '0;
            end else begin
              next_reps   = repsPlus; // R5
              next_rewind = 1'b1;
            end
          end else if (unitIn.count != '0) begin
            next_loopActive = 1'b1; // R5
            next_loopPos    = unitIn.pos;
            next_loopCount  = unitIn.count;
            next_reps       = '0;
            next_rewind     = 1'b1;
          end
        end
        default: begin
          if (localMode && unitIn.frontPanel) begin
            fpReject = 1'b1; // R7
          end else begin
            next_execStrobe = 1'b1;
            next_execUnit   = unitIn;
          end
        end
      endcase
    end
    if (clearAll) begin
      next_state      = ST_IDLE; // R4 R7
      next_loopActive = 1'b0;
      next_reps       = '0;
      next_localMode  = 1'b0;
      next_flush      = 1'b1;
      next_execStrobe = 1'b0;
      next_rewind     = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state        <= ST_IDLE;
      loopActive   <= 1'b0;
      loopPos      <= '0;
      loopCount    <= '0;
      reps         <= '0;
      localMode    <= 1'b0;
      rewind       <= 1'b0;
      flushBuffers <= 1'b0;
      execStrobe   <= 1'b0;
      execUnit     <= '0;
    end else begin
      state        <= next_state;
      loopActive   <= next_loopActive;
      loopPos      <= next_loopPos;
      loopCount    <= next_loopCount;
      reps         <= next_reps;
      localMode    <= next_localMode;
      rewind       <= next_rewind;
      flushBuffers <= next_flush;
      execStrobe   <= next_execStrobe;
      execUnit     <= next_execUnit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sweep, enables and power-on strap

  assign eosEvent = traceUpdated && (sweepPend || sweepFinished); // R21
  assign sweepEff = cfg.sweepDoneReq && !(talkOnly || listenOnly); // R10
  assign rqsEff = cfg.serviceReq && !(talkOnly || listenOnly); // R10
  assign powerOnEvt = bootCnt == `BOOT_CAPTURE && strapSync; // R14
  assign enableOut = cfg;

  always_comb begin
    next_sweepPend = (sweepPend || sweepFinished) && !traceUpdated;
    next_cfg       = enableWrite ? enableIn : cfg;
    next_bootCnt   = (bootCnt == `BOOT_LAST) ? bootCnt : 2'(bootCnt + 1'b1);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sweepPend <= 1'b0;
      cfg       <= '{sweepDoneReq: `RST_SWEEP_REQ_EN, serviceReq: `RST_SERVICE_EN, warningReport: `RST_WARN_EN};
      bootCnt   <= 2'h0;
      strapMeta <= 1'b0;
      strapSync <= 1'b0;
    end else begin
      sweepPend <= next_sweepPend;
      cfg       <= next_cfg;
      bootCnt   <= next_bootCnt;
      strapMeta <= powerOnStrap;
      strapSync <= strapMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status events and stack

  always_comb begin
    raw                = '0;
    raw[`EV_PWRON]     = powerOnEvt;
    raw[`EV_INT_ERR]   = internalError; // R18
    raw[`EV_CMD_ERR]   = cmdError; // R17
    raw[`EV_EXEC_ERR]  = execError || fpReject; // R18
    raw[`EV_EXEC_WARN] = warnValid && cfg.warningReport && isWarnCode(warnCode); // R12 R19
    raw[`EV_INT_WARN]  = internalWarn && cfg.warningReport; // R12 R19
    raw[`EV_EOS]       = eosEvent && sweepEff; // R9
    pushIdx            = firstPending(pend);
    pushData           = entryFor(pushIdx, rqsEff, sweepEff); // R11 R16
    stackPush          = 1'b0;
    if (pend != '0) begin
      stackPush = pushData.abnormal ? (int'(count) < DEPTH) : (int'(count) < DEPTH - 1); // R24
    end
    next_pend = pend;
    if (pend != '0) begin
      next_pend[pushIdx] = 1'b0;
    end
    next_pend = next_pend | raw;
    if (count != '0) begin
      next_statusByte = {1'b0, head.srq, head.abnormal, busy, head.code}; // R15
    end else begin
      next_statusByte = {1'b0, 1'b0, 1'b0, busy, `CODE_ORDINARY}; // R16
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend       <= '0;
      statusByte <= 8'h00;
    end else begin
      pend       <= next_pend;
      statusByte <= next_statusByte; // R13
    end
  end

  assign srq = (count != '0) && head.srq; // R9 R11

  status_stack #(
    .WIDTH ($bits(status_entry_s)),
    .DEPTH (DEPTH)
  ) u_stack (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .push     (stackPush),
    .pushData (pushData),
    .pop      (spollDone), // R22
    .headData (head),
    .count    (count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence waitEntered;
    unitTake && unitIn.kind == UNIT_WAIT && !(singleSweepMode && !singleSweepArm);
  endsequence

  sequence waitEnds;
    state == ST_WAIT && eosEvent && !clearAll;
  endsequence

  chk_wait_enter: assert property (waitEntered |=> state == ST_WAIT && busy && !unitTake) // R1
    else $error("wait not entered");
  chk_wait_end: assert property (waitEnds |=> state == ST_IDLE) // R2
    else $error("wait not ended by sweep");
  chk_wait_skip: assert property (unitTake && unitIn.kind == UNIT_WAIT && singleSweepMode && !singleSweepArm
                                  |=> state == ST_IDLE) // R3
    else $error("unarmed wait not skipped");
  chk_clear_flush: assert property (clearAll |=> flushBuffers && state == ST_IDLE && !loopActive && !execStrobe) // R4
    else $error("clear did not flush");
  chk_loop_keep: assert property (loopActive && !clearAll && !unitTake |=> loopActive) // R7
    else $error("loop aborted without clear");
  chk_local_cap: assert property (unitTake && unitIn.kind == UNIT_REPEAT && loopActive && unitIn.pos == loopPos
                                  && localMode && repsPlus >= 24'd256 && !clearAll |=> !loopActive && !rewind) // R8
    else $error("local cap not applied");
  chk_mode_force: assert property ((talkOnly || listenOnly) |-> !rqsEff && !sweepEff) // R10
    else $error("enables not forced off");
  chk_srq_mask: assert property (stackPush && pushData.abnormal |-> pushData.srq == rqsEff) // R11
    else $error("abnormal request not gated");
  chk_eos_srq: assert property (stackPush && pushIdx == `EV_EOS |-> pushData.srq == (rqsEff && sweepEff)) // R9
    else $error("sweep request gating wrong");
  chk_byte_busy: assert property (busy |=> statusByte[`SB_BUSY_BIT] && !statusByte[`SB_ZERO_BIT]) // R20
    else $error("busy bit not reported");
  chk_poll_pop: assert property (spollDone && count != '0 && !stackPush |=> int'(count) == int'($past(count)) - 1) // R22
    else $error("poll did not clear entry");

endmodule

// ==== test/msg_buffer_model.sv ====
`timescale 1ns/100ps
module msg_buffer_model
  import gpib_exec_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // unit handshake
  input  wire logic unitTake,
  input  wire logic rewind,
  input  wire logic flushBuffers,
  output logic      unitValid,
  output msg_unit_s unitIn
);
  msg_unit_s mem [4];
  int        len = 0;
  int        idx = 0;

  // bench hands over a whole message
  task automatic load(input msg_unit_s a, b, c, d, input int n);
    mem = '{a, b, c, d};
    len = n;
    idx = 0;
  endtask

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      len <= 0;
      idx <= 0;
    end else if (flushBuffers) begin
      len <= 0;
      idx <= 0;
    end else if (rewind) begin
      idx <= 0;
    end else if (unitValid && unitTake) begin
      idx <= idx + 1;
    end
  end

  // no stale unit once the message is used up
  assign unitValid = (idx < len);
  assign unitIn    = unitValid ? mem[idx[1:0]] : ~mem[0];
endmodule

// ==== test/gpib_status_and_message_exec_tb.sv ====
`timescale 1ns/100ps
module gpib_status_and_message_exec_tb
  import gpib_exec_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        arst_n, unitValid, unitTake, rewind, flushBuffers, execStrobe;
  msg_unit_s   unitIn, execUnit, nil, fp;
  logic        engineBusy, singleSweepMode, singleSweepArm, sweepFinished, traceUpdated;
  logic        devClear, selDevClear, listenAddressed, talkOnly, listenOnly, spollDone;
  logic [7:0]  statusByte, warnCode;
  logic        srq, nrfd, busy, frontPanelLocalReturn, powerOnStrap, enableWrite;
  enable_cfg_s enableIn, enableOut;
  logic        cmdError, execError, internalError, warnValid, internalWarn;
  int          n_errors = 0;
  int          n_checks = 0;
  int          nExec = 0;
  int          nPos0 = 0;
  int          nFlush = 0;
  int          a, b, held;
  logic [7:0]  expQ [$];
  int          warnList [7] = '{50, 52, 53, 54, 110, 111, 130};

  gpib_status_and_message_exec #(.DEPTH(8)) dut (
    .core_clk, .arst_n, .unitValid, .unitIn, .unitTake, .rewind, .flushBuffers,
    .execStrobe, .execUnit, .engineBusy, .singleSweepMode, .singleSweepArm,
    .sweepFinished, .traceUpdated, .devClear, .selDevClear, .listenAddressed,
    .talkOnly, .listenOnly, .spollDone, .statusByte, .srq, .nrfd, .busy,
    .frontPanelLocalReturn, .powerOnStrap, .enableWrite, .enableIn, .enableOut,
    .cmdError, .execError, .internalError, .warnValid, .warnCode, .internalWarn
  );
  msg_buffer_model bufModel (
    .core_clk, .arst_n, .unitTake, .rewind, .flushBuffers, .unitValid, .unitIn
  );

  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (execStrobe === 1'b1) begin
      nExec++;
      if (execUnit.pos === 8'h00) nPos0++;
    end
    if (flushBuffers === 1'b1) nFlush++;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  function automatic msg_unit_s u(input unit_kind_e k, input int p, input int c);
    u = '{kind: k, frontPanel: 1'b0, pos: p[7:0], count: c[23:0]};
  endfunction

  // wait until the buffer is empty and the block is quiet
  task automatic settle();
    int quiet;
    quiet = 0;
    for (int i = 0; i < 5000 && quiet < 4; i++) begin
      cyc(1);
      quiet = (!unitValid && busy === 1'b0) ? quiet + 1 : 0;
    end
    if (quiet < 4) begin
      n_errors++;
      $display("mismatch at %0t: block never went idle", $time);
      summarize();
    end
  endtask

  // poll out every expected entry in order
  task automatic drain();
    cyc(8);
    while (expQ.size() > 0) begin
      check(32'(statusByte), 32'(expQ[0]), "status");
      check(32'(srq), 32'(expQ[0][6]), "srq level");
      void'(expQ.pop_front());
      pulse(spollDone);
      cyc(3);
    end
    check(32'(statusByte), 32'h0, "empty status");
    check(32'(srq), 32'h0, "srq idle");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(81025));
    arst_n = 1'b0;
    {engineBusy, singleSweepMode, singleSweepArm, sweepFinished, traceUpdated} = '0;
    {devClear, selDevClear, listenAddressed, talkOnly, listenOnly, spollDone} = '0;
    {frontPanelLocalReturn, powerOnStrap, enableWrite, cmdError, execError} = '0;
    {internalError, warnValid, internalWarn} = '0;
    warnCode = 8'h00;
    enableIn = 3'h7;
    nil = u(UNIT_ORDINARY, 9, 0);
    repeat (2) @(posedge core_clk);
    #1;
    check(32'(enableOut), 32'h3, "enable defaults");
    arst_n = 1'b1;
    cyc(8);
    check(32'(statusByte), 32'h0, "no power-on entry");
    // engine stall then one ordinary unit
    engineBusy = 1'b1;
    bufModel.load(u(UNIT_ORDINARY, 0, 0), nil, nil, nil, 1);
    cyc(4);
    check(32'(nExec), 0, "held by engine");
    check(32'(busy), 1, "busy while buffered");
    engineBusy = 1'b0;
    settle();
    check(32'(nExec), 1, "ordinary unit");
    // nested repeats with random counts
    for (int i = 0; i < 3; i++) begin
      a = $urandom_range(3);
      b = $urandom_range(3);
      nExec = 0;
      nPos0 = 0;
      bufModel.load(u(UNIT_ORDINARY, 0, 0), u(UNIT_REPEAT, 1, a), u(UNIT_ORDINARY, 2, 0), u(UNIT_REPEAT, 3, b), 4);
      settle();
      check(32'(nPos0), 32'(a + b + 1), "inner passes");
      check(32'(nExec), 32'(a + 2 * b + 2), "all passes");
    end
    // local return caps a long loop, front-panel unit refused
    nPos0 = 0;
    fp = u(UNIT_ORDINARY, 1, 0);
    fp.frontPanel = 1'b1;
    bufModel.load(u(UNIT_ORDINARY, 0, 0), fp, u(UNIT_REPEAT, 2, 1000), nil, 3);
    cyc(20);
    pulse(frontPanelLocalReturn);
    settle();
    check(32'(nPos0), 257, "local cap");
    repeat (8) expQ.push_back(8'h62);
    drain();
    // device clear aborts a maximal loop
    bufModel.load(u(UNIT_ORDINARY, 0, 0), u(UNIT_REPEAT, 1, 16777215), nil, nil, 2);
    cyc(30);
    pulse(devClear);
    held = nExec;
    cyc(2);
    settle();
    check(32'(nExec), 32'(held), "loop aborted");
    check(32'(nFlush), 1, "flush on clear");
    // wait for end of sweep
    pulse(enableWrite);
    listenAddressed = 1'b1;
    nExec = 0;
    bufModel.load(u(UNIT_WAIT, 0, 0), u(UNIT_ORDINARY, 1, 0), nil, nil, 2);
    cyc(6);
    check(32'(nExec), 0, "held by wait");
    check(32'({busy, nrfd, unitTake}), 32'h6, "busy listener");
    pulse(sweepFinished);
    cyc(3);
    check(32'(nExec), 0, "trace pending");
    pulse(traceUpdated);
    settle();
    check(32'(nExec), 1, "after sweep");
    expQ.push_back(8'h42);
    drain();
    // unarmed single sweep, then armed wait cleared
    singleSweepMode = 1'b1;
    nExec = 0;
    bufModel.load(u(UNIT_WAIT, 0, 0), u(UNIT_ORDINARY, 1, 0), nil, nil, 2);
    settle();
    check(32'(nExec), 1, "unarmed skip");
    singleSweepArm = 1'b1;
    nExec = 0;
    bufModel.load(u(UNIT_WAIT, 0, 0), u(UNIT_ORDINARY, 1, 0), nil, nil, 2);
    cyc(6);
    listenAddressed = 1'b0;
    pulse(selDevClear);
    cyc(2);
    check(32'(nFlush), 1, "selected clear ignored");
    listenAddressed = 1'b1;
    pulse(selDevClear);
    settle();
    check(32'(nExec), 0, "wait cleared");
    check(32'(nFlush), 2, "flush on selected clear");
    {singleSweepMode, singleSweepArm} = 2'h0;
    // error classes in one cycle
    {cmdError, execError, internalError} = 3'h7;
    cyc(1);
    {cmdError, execError, internalError} = 3'h0;
    expQ = '{8'h63, 8'h61, 8'h62};
    drain();
    foreach (warnList[i]) begin
      warnCode = 8'(warnList[i]);
      pulse(warnValid);
      expQ.push_back(8'h65);
      drain();
    end
    pulse(internalWarn);
    expQ.push_back(8'h66);
    drain();
    warnCode = 8'(56 + $urandom_range(40));
    pulse(warnValid);
    drain();
    // warnings gated off
    enableIn = 3'h6;
    pulse(enableWrite);
    warnCode = 8'h32;
    pulse(warnValid);
    pulse(internalWarn);
    drain();
    // service request masked
    enableIn = 3'h5;
    pulse(enableWrite);
    pulse(cmdError);
    expQ.push_back(8'h21);
    drain();
    // talk-only and listen-only force both enables off
    for (int m = 1; m < 3; m++) begin
      enableIn = 3'($urandom_range(7));
      pulse(enableWrite);
      {talkOnly, listenOnly} = 2'(m);
      pulse(cmdError);
      pulse(sweepFinished);
      pulse(traceUpdated);
      expQ.push_back(8'h21);
      drain();
    end
    {talkOnly, listenOnly} = 2'h0;
    enableIn = 3'h7;
    pulse(enableWrite);
    // overfill the stack
    repeat (10) begin
      pulse(cmdError);
      cyc(1);
    end
    repeat (8) expQ.push_back(8'h61);
    drain();
    // power-on entry selected by the strap
    arst_n = 1'b0;
    powerOnStrap = 1'b1;
    cyc(2);
    arst_n = 1'b1;
    expQ.push_back(8'h41);
    drain();
    summarize();
  end
endmodule
